// [fprw_cmd.v]
// Resume, burst wrap and write enable command decoder
// How it works
// R01: 7Ah and D0h both mean resume
// R02: Resume needs a suspended flag and ready
// R03: Resume ignores the write enable latch
// R04: Resume is one opcode byte, no address
// R05: Resume clears matching suspended flag, then suspend once none held
// R06: Resume sets busy; operation restarts after latency
// R07: Resume needs whole bytes before chip select
// R08: Suspend ignored while resume latency runs
// R09: Both suspended: program resumes first
// R10: 77h sets wrap used by quad reads
// R11: Wrapped read runs to line end, wraps
// R12: Wrap: opcode, six address nibbles, ignored
// R13: Only bits six to four of wrap byte
// R14: Disable bit off; size bits pick 8..64
// R15: Wrap setting persists until the next wrap command
// R16: Partial wrap frame leaves setting unchanged
// R17: 06h sets write enable latch at deselect
// R18: Write enable gates program, erase, status writes
// R19: Opcodes shift in MSB first, eight clocks
// R20: Suspend sets suspend flags, clears busy
// R21: Wrap line naturally aligned to its length
// R22: Act only at deselect after whole bytes
`timescale 1ns/10ps
`include "fprw_defs.vh"
module fprw_cmd #(
  parameter RES_LAT_NS  = `FPRW_RES_LAT_NS,
  parameter RES_CYCLES  = RES_LAT_NS / `FPRW_CLK_NS
) (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_sck_i,
  input  wire [3:0]  spi_io_i,
  input  wire        op_done_i,
  input  wire        op_kind_erase_i,
  input  wire        op_running_i,
  input  wire        rd_load_i,
  input  wire        rd_step_i,
  input  wire [23:0] rd_start_addr_i,
  output reg         ready_busy_flag_o,
  output reg         erase_suspended_flag_o,
  output reg         program_suspended_flag_o,
  output reg         suspend_flag_o,
  output reg         write_enable_latch_o,
  output reg         wrap_disable_bit_o,
  output reg         wrap_size_msb_o,
  output reg         wrap_size_lsb_o,
  output reg         resume_pending_o,
  output reg         resume_program_o,
  output reg         resume_erase_o,
  output reg         protected_cmd_go_o,
  output reg         protected_cmd_refused_o,
  output reg  [7:0]  protected_opcode_o,
  output reg  [23:0] rd_addr_o
);
  localparam ST_OPC  = 3'b001;
  localparam ST_ADDR = 3'b010;
  localparam ST_WRAP = 3'b100;
  localparam [31:0] RES_CNT = (RES_CYCLES < 1) ? 32'd1 : RES_CYCLES;

  // Chip select passes inverted so a cleared synchroniser reads as deselected
  wire [5:0] sync_out;
  fprw_sync #(.WIDTH(6)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    ({~spi_cs_n_i, spi_sck_i, spi_io_i}),
    .sync_o     (sync_out)
  );
  wire       cs_n = ~sync_out[5];
  wire       sck  = sync_out[4];
  wire [3:0] io   = sync_out[3:0];

  reg        sck_d;
  reg        cs_n_d;
  reg [2:0]  state;
  reg [2:0]  bit_cnt;
  reg [3:0]  nib_cnt;
  reg [7:0]  shift;
  reg [7:0]  opcode;
  reg        byte_ok;
  reg        frame_bad;
  reg        wrap_done;
  reg [7:0]  wrap_byte;
  reg [31:0] res_timer;

  wire sck_rise = sck & ~sck_d;
  wire cs_rise  = cs_n & ~cs_n_d;
  wire [7:0] next_shift = {shift[6:0], io[0]};

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      sck_d  <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d  <= sck;
      cs_n_d <= cs_n;
    end
  end

  // Frame capture
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state     <= ST_OPC;
      bit_cnt   <= 3'h0;
      nib_cnt   <= 4'h0;
      shift     <= 8'h00;
      opcode    <= 8'h00;
      byte_ok   <= 1'b1;
      frame_bad <= 1'b0;
      wrap_done <= 1'b0;
      wrap_byte <= 8'h00;
    end else if (cs_n) begin
      state     <= ST_OPC;
      bit_cnt   <= 3'h0;
      nib_cnt   <= 4'h0;
      byte_ok   <= 1'b1;
      if (!cs_rise) begin
        frame_bad <= 1'b0;
        wrap_done <= 1'b0;
        opcode    <= 8'h00;
      end
    end else if (sck_rise) begin
      case (state)
        ST_OPC: begin
          shift   <= next_shift; // [R19]
          bit_cnt <= bit_cnt + 3'h1;
          byte_ok <= (bit_cnt == `FPRW_BITS_PER_BYTE);
          if (bit_cnt == `FPRW_BITS_PER_BYTE) begin
            opcode <= next_shift;
            if (next_shift == `FPRW_OP_WRAP) begin
              state <= ST_ADDR;
            end else begin
              state     <= ST_WRAP;
              frame_bad <= 1'b1;
            end
          end
        end
        ST_ADDR: begin
          // Address nibbles ignored [R12]
          nib_cnt <= nib_cnt + 4'h1;
          byte_ok <= nib_cnt[0];
          if (nib_cnt == `FPRW_ADDR_NIBBLES - 4'h1) begin
            nib_cnt <= 4'h0;
            state   <= ST_WRAP;
          end
        end
        ST_WRAP: begin
          if (opcode == `FPRW_OP_WRAP && !wrap_done) begin
            wrap_byte <= {wrap_byte[3:0], io};
            nib_cnt   <= nib_cnt + 4'h1;
            byte_ok   <= nib_cnt[0];
            if (nib_cnt == `FPRW_WRAP_NIBBLES - 4'h1) begin
              wrap_done <= 1'b1;
            end
          end else begin
            bit_cnt <= bit_cnt + 3'h1;
            byte_ok <= (bit_cnt == `FPRW_BITS_PER_BYTE);
          end
        end
        default: state <= ST_OPC;
      endcase
    end
  end

  // Execute at deselect on a byte boundary [R22] [R07] [R16]
  wire exec      = cs_rise & byte_ok & (opcode != 8'h00 || frame_bad);
  wire is_resume = (opcode == `FPRW_OP_RESUME_A) | (opcode == `FPRW_OP_RESUME_B); // [R01]
  // Single opcode byte only: extra clocks in ST_WRAP set extra_seen
  wire one_byte  = (bit_cnt == 3'h0) & (state == ST_WRAP); // [R04]
  wire is_suspend_flag   = (opcode == `FPRW_OP_SUSPEND_A) | (opcode == `FPRW_OP_SUSPEND_B);
  reg  extra_seen;
  reg  is_protected;
  always @* begin
    case (opcode)
      `FPRW_OP_PP, `FPRW_OP_DPP, `FPRW_OP_QPP, `FPRW_OP_SEQ_A, `FPRW_OP_SEQ_B,
      `FPRW_OP_ER4K, `FPRW_OP_ER32K, `FPRW_OP_ER64K, `FPRW_OP_CHIP_A,
      `FPRW_OP_CHIP_B, `FPRW_OP_OTP, `FPRW_OP_WRSR1, `FPRW_OP_WRSR2,
      `FPRW_OP_WRSR3, `FPRW_OP_WRSRI: is_protected = 1'b1;
      default:                         is_protected = 1'b0;
    endcase
  end

  // Wrap byte nibbles are payload; only clocks past the full command are extra
  wire trail_phase = (opcode != `FPRW_OP_WRAP) | wrap_done;
  always @(posedge core_clk_i) begin
    if (reset_i | cs_n) begin
      extra_seen <= 1'b0;
    end else if (sck_rise && state == ST_WRAP && trail_phase) begin
      extra_seen <= 1'b1;
    end
  end

  // Opcode-only commands end right after their eighth clock [R04] [R07]
  wire single_ok = one_byte & ~extra_seen;
  wire resume_ok = exec & is_resume & single_ok &
                   (erase_suspended_flag_o | program_suspended_flag_o) &
                   ~ready_busy_flag_o; // [R02] [R03]
  wire suspend_flag_ok   = exec & is_suspend_flag & single_ok & ready_busy_flag_o; // [R20]
  wire wren_ok   = exec & (opcode == `FPRW_OP_WREN) & single_ok; // [R17]
  wire wrap_ok   = exec & (opcode == `FPRW_OP_WRAP) & wrap_done & ~extra_seen; // [R16]

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ready_busy_flag_o        <= 1'b0;
      erase_suspended_flag_o   <= 1'b0;
      program_suspended_flag_o <= 1'b0;
      suspend_flag_o           <= 1'b0;
      write_enable_latch_o     <= 1'b0;
      wrap_disable_bit_o       <= `FPRW_WRAP_RESET;
      wrap_size_msb_o          <= 1'b0;
      wrap_size_lsb_o          <= 1'b0;
      resume_pending_o         <= 1'b0;
      resume_program_o         <= 1'b0;
      resume_erase_o           <= 1'b0;
      protected_cmd_go_o       <= 1'b0;
      protected_cmd_refused_o  <= 1'b0;
      protected_opcode_o       <= 8'h00;
      res_timer                <= 32'd0;
    end else begin
      resume_program_o        <= 1'b0;
      resume_erase_o          <= 1'b0;
      protected_cmd_go_o      <= 1'b0;
      protected_cmd_refused_o <= 1'b0;
      if (op_running_i && !resume_pending_o) begin
        ready_busy_flag_o <= 1'b1;
      end
      if (op_done_i) begin
        ready_busy_flag_o <= 1'b0;
      end
      if (resume_ok) begin
        ready_busy_flag_o <= 1'b1; // [R06]
        resume_pending_o  <= 1'b1;
        res_timer         <= RES_CNT;
        if (program_suspended_flag_o) begin
          // Program restarts first when both are held [R09]
          program_suspended_flag_o <= 1'b0; // [R05]
          resume_program_o         <= 1'b1;
          suspend_flag_o           <= erase_suspended_flag_o; // [R05]
        end else begin
          erase_suspended_flag_o <= 1'b0; // [R05]
          resume_erase_o         <= 1'b1;
          suspend_flag_o         <= 1'b0; // [R05]
        end
      end else if (resume_pending_o) begin
        // Countdown of the resume latency [R06]
        if (res_timer <= 32'd1) begin
          resume_pending_o <= 1'b0; // [R06]
        end
        res_timer <= res_timer - 32'd1;
      end else if (suspend_flag_ok) begin
        // Suspend accepted only outside resume latency [R08] [R20]
        suspend_flag_o    <= 1'b1;
        ready_busy_flag_o <= 1'b0;
        if (op_kind_erase_i) begin
          erase_suspended_flag_o <= 1'b1;
        end else begin
          program_suspended_flag_o <= 1'b1;
        end
      end
      if (wren_ok) begin
        write_enable_latch_o <= 1'b1; // [R17]
      end
      if (wrap_ok) begin
        // Only W6:W4 kept; setting holds until next wrap command [R10] [R13] [R14] [R15]
        wrap_disable_bit_o <= wrap_byte[`FPRW_WRAP_DIS_BIT];
        wrap_size_msb_o    <= wrap_byte[`FPRW_WRAP_MSB_BIT];
        wrap_size_lsb_o    <= wrap_byte[`FPRW_WRAP_LSB_BIT];
      end
      // Each accepted protected command uses up the latch
      if (exec && is_protected) begin
        protected_opcode_o <= opcode;
        if (write_enable_latch_o) begin
          protected_cmd_go_o   <= 1'b1; // [R18]
          write_enable_latch_o <= 1'b0;
        end else begin
          protected_cmd_refused_o <= 1'b1; // [R18]
        end
      end
    end
  end

  // Read address walk for the quad reads that follow a wrap setting
  wire [23:0] rd_addr_w;
  fprw_wrap_addr u_wrap (
    .core_clk_i   (core_clk_i),
    .reset_i      (reset_i),
    .load_i       (rd_load_i),
    .step_i       (rd_step_i),
    .start_addr_i (rd_start_addr_i),
    .wrap_on_i    (~wrap_disable_bit_o), // [R14]
    .wrap_size_i  ({wrap_size_msb_o, wrap_size_lsb_o}),
    .addr_o       (rd_addr_w)
  );
  // Registered copy keeps the port straight off a flop
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_addr_o <= 24'h000000;
    end else begin
      rd_addr_o <= rd_addr_w;
    end
  end
endmodule

// [fprw_defs.vh]
// Constants for the resume, wrap and write-enable command decoder
`ifndef FPRW_DEFS_VH
`define FPRW_DEFS_VH
`define FPRW_OP_RESUME_A   8'h7A
`define FPRW_OP_RESUME_B   8'hD0
`define FPRW_OP_WRAP       8'h77
`define FPRW_OP_WREN       8'h06
`define FPRW_OP_PP         8'h02
`define FPRW_OP_DPP        8'hA2
`define FPRW_OP_QPP        8'h32
`define FPRW_OP_SEQ_A      8'hAF
`define FPRW_OP_SEQ_B      8'hAD
`define FPRW_OP_ER4K       8'h20
`define FPRW_OP_ER32K      8'h52
`define FPRW_OP_ER64K      8'hD8
`define FPRW_OP_CHIP_A     8'h60
`define FPRW_OP_CHIP_B     8'hC7
`define FPRW_OP_OTP        8'h9B
`define FPRW_OP_WRSR1      8'h01
`define FPRW_OP_WRSR2      8'h31
`define FPRW_OP_WRSR3      8'h11
`define FPRW_OP_WRSRI      8'h71
`define FPRW_OP_SUSPEND_A  8'h75
`define FPRW_OP_SUSPEND_B  8'hB0
`define FPRW_ADDR_NIBBLES  4'h6
`define FPRW_WRAP_NIBBLES  4'h2
`define FPRW_BITS_PER_BYTE 3'h7
`define FPRW_WRAP_DIS_BIT  4
`define FPRW_WRAP_MSB_BIT  6
`define FPRW_WRAP_LSB_BIT  5
`define FPRW_WRAP_RESET    1'b1
`define FPRW_RES_LAT_NS    20000
`define FPRW_CLK_NS        10
`endif

// [fprw_sync.v]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module fprw_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      stage1 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// [fprw_wrap_addr.v]
// Wrapped read address generator for burst reads
`timescale 1ns/10ps
`include "fprw_defs.vh"
module fprw_wrap_addr (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        load_i,
  input  wire        step_i,
  input  wire [23:0] start_addr_i,
  input  wire        wrap_on_i,
  input  wire [1:0]  wrap_size_i,
  output reg  [23:0] addr_o
);
  reg [5:0] mask;
  always @* begin
    case (wrap_size_i)
      2'h0:    mask = 6'h07;
      2'h1:    mask = 6'h0F;
      2'h2:    mask = 6'h1F;
      default: mask = 6'h3F;
    endcase
  end
  wire [23:0] inc = addr_o + 24'h000001;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      addr_o <= 24'h000000;
    end else if (load_i) begin
      addr_o <= start_addr_i;
    end else if (step_i) begin
      if (wrap_on_i) begin
        // Only low bits inside the aligned line move [R11] [R21]
        addr_o <= {addr_o[23:6], (addr_o[5:0] & ~mask) | (inc[5:0] & mask)};
      end else begin
        addr_o <= inc;
      end
    end
  end
endmodule

// [fprw_host.sv]
// Host controller model driving chip select, link clock and data lines
`timescale 1ns/10ps
module fprw_host (
  input  wire        core_clk_i,
  output logic       spi_cs_n_o,
  output logic       spi_sck_o,
  output logic [3:0] spi_io_o
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sck_o  = 1'b0;
    spi_io_o   = 4'hA;
  end
  // One link clock of 80 ns; data set while the clock is low
  task automatic tick(input logic [3:0] v);
    spi_io_o = v;
    #40 spi_sck_o = 1'b1;
    #40 spi_sck_o = 1'b0;
  endtask
  // Serial bits of the opcode, then nibbles high first; lines turn over when released
  task automatic frame(input logic [7:0] op, input int ns,
                       input logic [31:0] q, input int nq);
    @(negedge core_clk_i);
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < ns; i++) tick({~spi_io_o[3:1], op[7-i]});
    for (int i = 0; i < nq; i++) tick(q[31-4*i -: 4]);
    #40 spi_cs_n_o = 1'b1;
    spi_io_o = ~spi_io_o;
    repeat (10) @(negedge core_clk_i);
  endtask
endmodule

// [fprw_cmd_assertions.sv]
// Port checker for the command decoder
`timescale 1ns/10ps
module fprw_cmd_assertions #(
  parameter RES_LAT_NS = 20000,
  parameter RES_CYCLES = 2000
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire spi_cs_n_i,
  input wire ready_busy_flag_o,
  input wire erase_suspended_flag_o,
  input wire program_suspended_flag_o,
  input wire suspend_flag_o,
  input wire write_enable_latch_o,
  input wire wrap_disable_bit_o,
  input wire wrap_size_msb_o,
  input wire wrap_size_lsb_o,
  input wire resume_pending_o,
  input wire resume_program_o,
  input wire resume_erase_o,
  input wire protected_cmd_go_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [31:0] pend_cnt;
  always @(posedge core_clk_i) begin
    if (reset_i || !resume_pending_o) pend_cnt <= 32'd0;
    else pend_cnt <= pend_cnt + 32'd1;
  end
  property p_plen; $fell(resume_pending_o) |-> pend_cnt == RES_CYCLES; endproperty
  a_plen: assert property (p_plen) else $error("resume latency length wrong");
  sequence s_taken; resume_program_o || resume_erase_o; endsequence
  sequence s_hold; resume_pending_o [*8]; endsequence
  property p_go; protected_cmd_go_o |-> $past(write_enable_latch_o); endproperty
  a_go: assert property (p_go) else $error("command run without latch");
  property p_rprog;
    resume_program_o |-> $past(program_suspended_flag_o) && !$past(ready_busy_flag_o)
      && !program_suspended_flag_o && ready_busy_flag_o;
  endproperty
  a_rprog: assert property (p_rprog) else $error("bad program resume");
  property p_rerase;
    resume_erase_o |-> $past(erase_suspended_flag_o) && !$past(program_suspended_flag_o)
      && !erase_suspended_flag_o;
  endproperty
  a_rerase: assert property (p_rerase) else $error("bad erase resume");
  property p_sfell;
    $fell(suspend_flag_o) |-> !erase_suspended_flag_o && !program_suspended_flag_o;
  endproperty
  a_sfell: assert property (p_sfell) else $error("suspend cleared early");
  property p_pend; s_taken |=> s_hold; endproperty
  a_pend: assert property (p_pend) else $error("latency dropped");
  property p_nosusp;
    resume_pending_o && $past(resume_pending_o) |-> !$rose(suspend_flag_o);
  endproperty
  a_nosusp: assert property (p_nosusp) else $error("suspend during latency");
  property p_wrap;
    $changed({wrap_disable_bit_o, wrap_size_msb_o, wrap_size_lsb_o})
      |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap changed in frame");
  property p_wel; $rose(write_enable_latch_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2); endproperty
  a_wel: assert property (p_wel) else $error("latch set in frame");
endmodule

bind fprw_cmd fprw_cmd_assertions #(.RES_LAT_NS(RES_LAT_NS), .RES_CYCLES(RES_CYCLES)) i_chk (
  .core_clk_i, .reset_i, .spi_cs_n_i, .ready_busy_flag_o, .erase_suspended_flag_o,
  .program_suspended_flag_o, .suspend_flag_o, .write_enable_latch_o, .wrap_disable_bit_o,
  .wrap_size_msb_o, .wrap_size_lsb_o, .resume_pending_o, .resume_program_o,
  .resume_erase_o, .protected_cmd_go_o
);

// [tb_top.sv]
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [7:0] op; int ns; logic [31:0] q; int nq; logic [3:0] ex;} fprw_row_t;
  logic        core_clk_i, reset_i, op_done_i, op_kind_erase_i, run, rd_load_i, rd_step_i;
  logic [23:0] rd_start_addr_i = 24'h001004;
  logic [3:0]  seen;
  logic        clr_seen;
  int          n_fail = 0;
  int          comparisons = 0;
  wire         spi_cs_n_i, spi_sck_i, ready_busy_flag_o, erase_suspended_flag_o, suspend_flag_o;
  wire         program_suspended_flag_o, write_enable_latch_o, wrap_disable_bit_o;
  wire         wrap_size_msb_o, wrap_size_lsb_o, resume_pending_o, resume_program_o;
  wire         resume_erase_o, protected_cmd_go_o, protected_cmd_refused_o;
  wire [3:0]   spi_io_i;
  wire [7:0]   protected_opcode_o;
  wire [23:0]  rd_addr_o;
  wire [3:0]   st = {ready_busy_flag_o, erase_suspended_flag_o, program_suspended_flag_o,
                     suspend_flag_o};
  wire [3:0]   wr = {write_enable_latch_o, wrap_size_msb_o, wrap_size_lsb_o, wrap_disable_bit_o};
  // Array engine: runs while requested unless its own kind is held suspended
  wire         op_running_i = run && !(op_kind_erase_i ? erase_suspended_flag_o
                                                        : program_suspended_flag_o);
  fprw_row_t   rows [8] = '{
    '{8'h06, 7, 32'h0, 0, 4'h1}, '{8'h06, 8, 32'h0, 0, 4'h9},
    '{8'h77, 8, 32'hABCDEF8F, 8, 4'h8}, '{8'h77, 8, 32'h123456A5, 8, 4'hA},
    '{8'h77, 8, 32'h00000040, 8, 4'hC}, '{8'h77, 8, 32'hFFFFFFEF, 8, 4'hE},
    '{8'h77, 8, 32'h55555570, 8, 4'hF}, '{8'h77, 8, 32'h00000000, 7, 4'hF}};
  logic [7:0]  prot [15] = '{8'h02, 8'hA2, 8'h32, 8'hAF, 8'hAD, 8'h20, 8'h52, 8'hD8,
                             8'h60, 8'hC7, 8'h9B, 8'h01, 8'h31, 8'h11, 8'h71};
  fprw_host i_fprw_host (.core_clk_i, .spi_cs_n_o(spi_cs_n_i), .spi_sck_o(spi_sck_i),
                         .spi_io_o(spi_io_i));
  fprw_cmd #(.RES_LAT_NS(2000)) i_fprw_cmd (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_sck_i(spi_sck_i), .spi_io_i(spi_io_i), .op_done_i(op_done_i),
    .op_kind_erase_i(op_kind_erase_i), .op_running_i(op_running_i), .rd_load_i(rd_load_i),
    .rd_step_i(rd_step_i), .rd_start_addr_i(rd_start_addr_i),
    .ready_busy_flag_o(ready_busy_flag_o), .erase_suspended_flag_o(erase_suspended_flag_o),
    .program_suspended_flag_o(program_suspended_flag_o), .suspend_flag_o(suspend_flag_o),
    .write_enable_latch_o(write_enable_latch_o), .wrap_disable_bit_o(wrap_disable_bit_o),
    .wrap_size_msb_o(wrap_size_msb_o), .wrap_size_lsb_o(wrap_size_lsb_o),
    .resume_pending_o(resume_pending_o), .resume_program_o(resume_program_o),
    .resume_erase_o(resume_erase_o), .protected_cmd_go_o(protected_cmd_go_o),
    .protected_cmd_refused_o(protected_cmd_refused_o),
    .protected_opcode_o(protected_opcode_o), .rd_addr_o(rd_addr_o));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (clr_seen) seen <= 4'h0;
    else seen <= seen | {protected_cmd_go_o, protected_cmd_refused_o, resume_program_o,
                         resume_erase_o};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    comparisons++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, ex);
    end
  endtask
  task automatic send(input logic [7:0] op, input int ns, input logic [31:0] q, input int nq);
    clr_seen = 1'b1;
    @(negedge core_clk_i);
    clr_seen = 1'b0;
    i_fprw_host.frame(op, ns, q, nq);
  endtask
  task automatic stop_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    {clr_seen, reset_i, op_done_i, op_kind_erase_i, run, rd_load_i, rd_step_i} = 7'h60;
    repeat (6) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    foreach (rows[i]) begin
      send(rows[i].op, rows[i].ns, rows[i].q, rows[i].nq);
      chk(wr, rows[i].ex);
    end
    send(8'h77, 8, 32'h00000020, 8);
    rd_load_i = 1'b1;
    @(negedge core_clk_i);
    {rd_load_i, rd_step_i} = 2'h1;
    repeat (12) @(negedge core_clk_i);
    rd_step_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk(rd_addr_o, 24'h001000);
    foreach (prot[i]) begin
      send(8'h06, 8, 0, 0);
      send(prot[i], 8, 0, 0);
      chk({seen, write_enable_latch_o, protected_opcode_o}, {4'h8, 1'b0, prot[i]});
      send(prot[i], 8, 0, 0);
      chk(seen, 4'h4);
    end
    send(8'h7A, 8, 0, 0);
    chk({seen, st}, 8'h00);
    {run, op_kind_erase_i} = 2'h3;
    send(8'h75, 8, 0, 0);
    chk(st, 4'h5);
    op_kind_erase_i = 1'b0;
    send(8'hB0, 8, 0, 0);
    chk(st, 4'h7);
    send(8'h7A, 7, 0, 0);
    chk({seen, st}, 8'h07);
    send(8'hD0, 8, 0, 0);
    chk({seen, st, resume_pending_o}, 9'h05B);
    send(8'h7A, 8, 0, 0);
    chk({seen, st}, 8'h0D);
    repeat (200) @(negedge core_clk_i);
    {op_kind_erase_i, op_done_i} = 2'h3;
    @(negedge core_clk_i);
    op_done_i = 1'b0;
    chk(st, 4'h5);
    send(8'h7A, 8, 0, 0);
    chk({seen, st}, 8'h18);
    send(8'h75, 8, 0, 0);
    chk(st, 4'h8);
    send(8'h06, 8, 0, 0);
    reset_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    chk({st, wr, resume_pending_o}, 9'h002);
    reset_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    send(8'h06, 8, 0, 0);
    chk({st, wr}, 8'h89);
    stop_test();
  end
endmodule
